//--- common/smp_defines.vh
// constants and functional notes for the six channel motor pwm unit
// Functional notes
// - six generators, each able to drive its own output pin independently.
// - complementary mode pairs 0/1, 2/3, 4/5 as inverses with dead-time.
// - synchronous mode drives both outputs of each pair in phase.
// - each pair shares one 8-bit prescaler of the source clock.
// - each channel divides prescaled clock by 1, 2, 4, 8 or 16.
// - each channel has a 16-bit down/up counter whose period sets cycle length.
// - each channel has a 16-bit comparator setting duty from compare value.
// - twelve flags, period match and compare match for each channel.
// - each flag has an enable; enabled set flag raises the interrupt request.
// - one-shot gives one cycle then stops; auto-reload runs continuously.
// - one-shot only with edge-aligned counting; auto-reload in every mode.
// - period and compare writes go to buffers, loaded at period end.
// - group control makes channels 2,4 follow 0 and 3,5 follow 1.
// - edge-aligned, center-aligned and precise center-aligned counting.
// - center modes use separate compare points when counting down and up.
// - center modes may load buffered values at the period center.
`ifndef SMP_DEFINES_VH
`define SMP_DEFINES_VH

// ----------------------------------------
// counting alignment codes
// ----------------------------------------
`define SMP_ALIGN_EDGE 2'h0
`define SMP_ALIGN_CENTER 2'h1
`define SMP_ALIGN_PRECISE 2'h2

// ----------------------------------------
// pair mode codes
// ----------------------------------------
`define SMP_PAIR_INDEP 2'h0
`define SMP_PAIR_COMP 2'h1
`define SMP_PAIR_SYNC 2'h2

// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define SMP_CNT_RST 16'h0000
`define SMP_BUF_RST 16'h0000
`define SMP_FLAG_PRD 0
`define SMP_FLAG_CMP 1

`endif

//--- verilog/smp_chan.v
// one pwm channel: buffers, down/up counter and comparator
`include "smp_defines.vh"
module smp_chan (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire tick,
  input wire en,
  input wire [1:0] align,
  input wire one_shot,
  input wire center_load,
  input wire buf_wr,
  input wire [15:0] buf_prd,
  input wire [15:0] buf_cdn,
  input wire [15:0] buf_cup,
  output wire lvl,
  output wire prd_hit,
  output wire cmp_hit,
  output wire run
);
  reg [15:0] prd_b_q, cdn_b_q, cup_b_q;
  reg [15:0] prd_a_q, cdn_a_q, cup_a_q;
  reg [15:0] cnt_q;
  reg up_q, hold_q, done_q;
  wire edge_m = (align == `SMP_ALIGN_EDGE);
  wire prec_m = (align == `SMP_ALIGN_PRECISE);
  wire os = one_shot & edge_m;
  wire [15:0] cmp_a = up_q ? cup_a_q : cdn_a_q;
  wire [15:0] top_n = (prd_b_q == 16'h0000) ? 16'h0000 : prd_b_q - 16'h0001;
  assign run = en & ~done_q;
  // duty from compare; separate up/down compare points
  assign lvl = run & (cnt_q <= cmp_a);
  assign prd_hit = tick & run & (cnt_q == prd_a_q);
  assign cmp_hit = tick & run & (cnt_q == cmp_a);

  // ----------------------------------------
  // buffers and counter
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prd_b_q <= `SMP_BUF_RST;
      cdn_b_q <= `SMP_BUF_RST;
      cup_b_q <= `SMP_BUF_RST;
      prd_a_q <= `SMP_BUF_RST;
      cdn_a_q <= `SMP_BUF_RST;
      cup_a_q <= `SMP_BUF_RST;
      cnt_q <= `SMP_CNT_RST;
      up_q <= 1'b0;
      hold_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      // software writes land in buffers only
      if (buf_wr) begin
        prd_b_q <= buf_prd;
        cdn_b_q <= buf_cdn;
        cup_b_q <= buf_cup;
      end
      if (!en) begin
        // idle: start from fresh buffered values
        prd_a_q <= prd_b_q;
        cdn_a_q <= cdn_b_q;
        cup_a_q <= cup_b_q;
        cnt_q <= prd_b_q;
        up_q <= 1'b0;
        hold_q <= 1'b0;
        done_q <= 1'b0;
      end else if (tick && !done_q) begin
        if (edge_m) begin
          // down counter, reload or stop at underflow
          if (cnt_q == 16'h0000) begin
            if (os) begin
              done_q <= 1'b1;
            end else begin
              prd_a_q <= prd_b_q;
              cdn_a_q <= cdn_b_q;
              cup_a_q <= cup_b_q;
              cnt_q <= prd_b_q;
            end
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end else if (!up_q) begin
          if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
          end else if (prec_m && !hold_q) begin
            hold_q <= 1'b1; // precise mode dwells one tick at center
          end else begin
            hold_q <= 1'b0;
            up_q <= 1'b1;
            cnt_q <= 16'h0001;
            // optional load at the center point
            if (center_load) begin
              prd_a_q <= prd_b_q;
              cdn_a_q <= cdn_b_q;
              cup_a_q <= cup_b_q;
            end
          end
        end else if (cnt_q < prd_a_q) begin
          cnt_q <= cnt_q + 16'h0001;
        end else if (prec_m && !hold_q) begin
          hold_q <= 1'b1;
        end else begin
          // period end at the top of the triangle
          hold_q <= 1'b0;
          up_q <= 1'b0;
          prd_a_q <= prd_b_q;
          cdn_a_q <= cdn_b_q;
          cup_a_q <= cup_b_q;
          cnt_q <= top_n;
        end
      end
    end
  end
endmodule

//--- verilog/smp_dtime.v
// dead-time generator for one complementary pair
module smp_dtime (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire lvl,
  input wire [7:0] dt,
  output wire hi,
  output wire lo
);
  reg lvl_q;
  reg [7:0] cnt_q;

  // ----------------------------------------
  // gap after every edge of the source level
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (clk_en) begin
      if (lvl != lvl_q) begin
        lvl_q <= lvl;
        cnt_q <= dt;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // inverse outputs, both low during the gap
  // zero gap gives both edges together
  assign hi = lvl_q & (cnt_q == 8'h00);
  assign lo = ~lvl_q & (cnt_q == 8'h00);
endmodule

//--- verilog/smp_pwm_unit.v
// six channel motor pwm unit top: clocks, pairing, flags, outputs
`include "smp_defines.vh"
module smp_pwm_unit (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire [5:0] pwm_en,
  input wire [1:0] pair_mode,
  input wire grp_en,
  input wire [1:0] align,
  input wire [5:0] one_shot,
  input wire center_load,
  input wire [23:0] presc_val,
  input wire [17:0] div_sel,
  input wire [23:0] dead_time,
  input wire [5:0] buf_wr,
  input wire [15:0] buf_prd,
  input wire [15:0] buf_cdn,
  input wire [15:0] buf_cup,
  input wire [11:0] int_en,
  input wire [11:0] flag_clr,
  output reg pwm_out_0,
  output reg pwm_out_1,
  output reg pwm_out_2,
  output reg pwm_out_3,
  output reg pwm_out_4,
  output reg pwm_out_5,
  output reg [11:0] flag_q,
  output reg pwm_irq,
  output reg [5:0] run_q
);
  // ----------------------------------------
  // shared pair prescalers
  // ----------------------------------------
  wire [2:0] ptick;
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_pre
      // local counter, so each process drives a signal of its own
      reg [7:0] pcnt_q;
      assign ptick[p] = (pcnt_q == presc_val[p*8 +: 8]);
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          pcnt_q <= 8'h00;
        end else if (clk_en) begin
          if (ptick[p] || !(pwm_en[2*p] | pwm_en[2*p+1])) begin
            pcnt_q <= 8'h00;
          end else begin
            pcnt_q <= pcnt_q + 8'h01;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // per channel dividers and generators
  // ----------------------------------------
  wire [5:0] tick;
  wire [5:0] lvl;
  wire [5:0] prd_hit;
  wire [5:0] cmp_hit;
  wire [5:0] run;
  genvar c;
  generate
    for (c = 0; c < 6; c = c + 1) begin : g_ch
      reg [3:0] dcnt_q;
      wire [2:0] sel = div_sel[c*3 +: 3];
      // divide codes above 4 fall back to 16
      wire [3:0] mask = (sel == 3'h0) ? 4'h0 :
                        (sel == 3'h1) ? 4'h1 :
                        (sel == 3'h2) ? 4'h3 :
                        (sel == 3'h3) ? 4'h7 : 4'hF;
      // pass or divide by 2, 4, 8, 16
      assign tick[c] = ptick[c/2] & ((dcnt_q & mask) == mask);
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          dcnt_q <= 4'h0;
        end else if (clk_en) begin
          if (!pwm_en[c]) begin
            dcnt_q <= 4'h0;
          end else if (ptick[c/2]) begin
            dcnt_q <= dcnt_q + 4'h1;
          end
        end
      end
      smp_chan u_chan (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .tick(tick[c]),
        .en(pwm_en[c]),
        .align(align),
        .one_shot(one_shot[c]),
        .center_load(center_load),
        .buf_wr(buf_wr[c]),
        .buf_prd(buf_prd),
        .buf_cdn(buf_cdn),
        .buf_cup(buf_cup),
        .lvl(lvl[c]),
        .prd_hit(prd_hit[c]),
        .cmp_hit(cmp_hit[c]),
        .run(run[c])
      );
    end
  endgenerate

  // ----------------------------------------
  // group control
  // ----------------------------------------
  // channels 2,4 follow 0 and 3,5 follow 1
  wire [5:0] src;
  assign src[0] = lvl[0];
  assign src[1] = lvl[1];
  assign src[2] = grp_en ? lvl[0] : lvl[2];
  assign src[3] = grp_en ? lvl[1] : lvl[3];
  assign src[4] = grp_en ? lvl[0] : lvl[4];
  assign src[5] = grp_en ? lvl[1] : lvl[5];

  // ----------------------------------------
  // dead-time and pair modes
  // ----------------------------------------
  wire [2:0] dt_hi;
  wire [2:0] dt_lo;
  reg [5:0] out_d;
  genvar d;
  generate
    for (d = 0; d < 3; d = d + 1) begin : g_dt
      smp_dtime u_dt (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .lvl(src[2*d]),
        .dt(dead_time[d*8 +: 8]),
        .hi(dt_hi[d]),
        .lo(dt_lo[d])
      );
    end
  endgenerate

  // pick pin levels by pair mode
  integer k;
  always @* begin
    out_d = src;
    for (k = 0; k < 3; k = k + 1) begin
      case (pair_mode)
        `SMP_PAIR_COMP: begin
          out_d[2*k] = dt_hi[k];
          out_d[2*k+1] = dt_lo[k];
        end
        `SMP_PAIR_SYNC: begin
          out_d[2*k+1] = src[2*k];
        end
        default: begin
          out_d[2*k] = src[2*k];
          out_d[2*k+1] = src[2*k+1];
        end
      endcase
    end
  end

  // ----------------------------------------
  // flags and interrupt request
  // ----------------------------------------
  reg [11:0] set_v;
  reg [11:0] flag_d;
  // own loop index, so the two processes never share a variable
  integer j;
  always @* begin
    for (j = 0; j < 6; j = j + 1) begin
      set_v[2*j + `SMP_FLAG_PRD] = prd_hit[j];
      set_v[2*j + `SMP_FLAG_CMP] = cmp_hit[j];
    end
    // set wins over a clear in the same cycle
    flag_d = (flag_q & ~flag_clr) | set_v;
  end

  // registered pins, flags and request
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_out_0 <= 1'b0;
      pwm_out_1 <= 1'b0;
      pwm_out_2 <= 1'b0;
      pwm_out_3 <= 1'b0;
      pwm_out_4 <= 1'b0;
      pwm_out_5 <= 1'b0;
      flag_q <= 12'h000;
      pwm_irq <= 1'b0;
      run_q <= 6'h00;
    end else if (clk_en) begin
      pwm_out_0 <= out_d[0];
      pwm_out_1 <= out_d[1];
      pwm_out_2 <= out_d[2];
      pwm_out_3 <= out_d[3];
      pwm_out_4 <= out_d[4];
      pwm_out_5 <= out_d[5];
      flag_q <= flag_d;
      pwm_irq <= |(flag_d & int_en);
      run_q <= run;
    end
  end
endmodule

//--- bench/smp_pwm_unit_asserts.sv
// checker on the ports of the six channel motor pwm unit
module smp_pwm_unit_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [5:0] pwm_en,
  input wire logic [1:0] pair_mode,
  input wire logic grp_en,
  input wire logic [1:0] align,
  input wire logic [5:0] one_shot,
  input wire logic [11:0] int_en,
  input wire logic [11:0] flag_clr,
  input wire logic pwm_out_0,
  input wire logic pwm_out_1,
  input wire logic pwm_out_2,
  input wire logic pwm_out_3,
  input wire logic pwm_out_4,
  input wire logic pwm_out_5,
  input wire logic [11:0] flag_q,
  input wire logic pwm_irq,
  input wire logic [5:0] run_q
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // pin and flag relations
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  property p_irq; $past(clk_en) |-> pwm_irq == |(flag_q & $past(int_en)); endproperty
  a_irq: assert property (p_irq) else $error("irq does not match flags");
  property p_comp; pair_mode == 2'h1 && $past(pair_mode) == 2'h1 && $past(pair_mode, 2) == 2'h1
    |-> !(pwm_out_0 && pwm_out_1) && !(pwm_out_2 && pwm_out_3) && !(pwm_out_4 && pwm_out_5);
  endproperty
  a_comp: assert property (p_comp) else $error("pair outputs overlap");
  property p_sync; pair_mode == 2'h2 && $past(pair_mode) == 2'h2
    |-> pwm_out_1 == pwm_out_0 && pwm_out_3 == pwm_out_2 && pwm_out_5 == pwm_out_4;
  endproperty
  a_sync: assert property (p_sync) else $error("pair pins differ");
  property p_grp; grp_en && $past(grp_en) && pair_mode == 2'h0 && $past(pair_mode) == 2'h0
    |-> pwm_out_2 == pwm_out_0 && pwm_out_4 == pwm_out_0 && pwm_out_3 == pwm_out_1
    && pwm_out_5 == pwm_out_1;
  endproperty
  a_grp: assert property (p_grp) else $error("group pins differ");
  property p_fell; $fell(run_q[1]) |-> !$past(pwm_en[1])
    || ($past(one_shot[1]) && $past(align) == 2'h0);
  endproperty
  a_fell: assert property (p_fell) else $error("channel stopped unexpectedly");
  property p_stop; !run_q[1] && !$past(run_q[1]) && pwm_en[1] && $past(pwm_en[1]) |=> !run_q[1];
  endproperty
  a_stop: assert property (p_stop) else $error("stopped channel restarted");
  property p_idle; (!pwm_en[0] && clk_en) [*4] |=> !pwm_out_0; endproperty
  a_idle: assert property (p_idle) else $error("idle pin driven high");
  property p_sticky; flag_q[0] && !flag_clr[0] && clk_en |=> flag_q[0]; endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");
endmodule

//--- bench/smp_stage_model.sv
// power stage model: counts cycles with both switches of a pair on in complementary mode
module smp_stage_model (
  input wire logic clk_sys,
  input wire logic [5:0] pins,
  input wire logic comp,
  output int shoot
);
  timeunit 1ns;
  timeprecision 100ps;
  // both switches on would short the rail, so only complementary use counts
  initial shoot = 0;
  always @(posedge clk_sys) begin
    if (comp && ((pins[0] && pins[1]) || (pins[2] && pins[3]) || (pins[4] && pins[5]))) begin
      shoot <= shoot + 1;
    end
  end
endmodule

//--- bench/smp_pwm_unit_test.sv
// testbench for the six channel motor pwm unit
`include "smp_defines.vh"
module smp_pwm_unit_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst_n, clk_en, grp_en, center_load, pwm_irq;
  logic [5:0] pwm_en, one_shot, buf_wr, run_q;
  logic [1:0] pair_mode, align;
  logic [23:0] presc_val, dead_time;
  logic [17:0] div_sel;
  logic [15:0] buf_prd, buf_cdn, buf_cup;
  logic [11:0] int_en, flag_clr, flag_q;
  wire [5:0] pins;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int shoot;
  int hexp[3] = '{24, 16, 18};
  int rexp[3] = '{12, 8, 6};
  smp_pwm_unit smp_pwm_unit_i (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .pwm_en(pwm_en), .pair_mode(pair_mode), .grp_en(grp_en), .align(align),
    .one_shot(one_shot), .center_load(center_load), .presc_val(presc_val),
    .div_sel(div_sel), .dead_time(dead_time), .buf_wr(buf_wr), .buf_prd(buf_prd),
    .buf_cdn(buf_cdn), .buf_cup(buf_cup), .int_en(int_en), .flag_clr(flag_clr),
    .pwm_out_0(pins[0]), .pwm_out_1(pins[1]), .pwm_out_2(pins[2]), .pwm_out_3(pins[3]),
    .pwm_out_4(pins[4]), .pwm_out_5(pins[5]), .flag_q(flag_q), .pwm_irq(pwm_irq),
    .run_q(run_q));
  smp_stage_model smp_stage_model_i (.clk_sys(clk_sys), .pins(pins),
    .comp(pair_mode == `SMP_PAIR_COMP), .shoot(shoot));
  // ----------------------------------------
  // clock, hang guard and helpers
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // the whole run needs well under this many cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      num_errors = num_errors + 1;
      results();
    end
  end
  task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %0d seen %0d", w, e, s);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // buffer write with one strobe pulse
  task automatic load(input int ch, input logic [15:0] p, input logic [15:0] c);
    @(posedge clk_sys);
    buf_wr <= 6'h01 << ch;
    buf_prd <= p;
    buf_cdn <= c;
    buf_cup <= 16'h0000;
    @(posedge clk_sys);
    buf_wr <= 6'h00;
    // one more edge so an idle channel copies the new buffers
    @(posedge clk_sys);
  endtask
  // window of whole periods, so counts do not depend on phase
  task automatic measure(input int pin, input int n, output int hi, output int rise);
    logic last;
    hi = 0;
    rise = 0;
    @(negedge clk_sys);
    last = pins[pin];
    repeat (n) begin
      @(negedge clk_sys);
      hi += pins[pin];
      rise += (pins[pin] && !last);
      last = pins[pin];
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_align();
    int h, r;
    for (int a = 2; a >= 0; a--) begin
      @(posedge clk_sys);
      pwm_en <= 6'h00;
      align <= a[1:0];
      center_load <= 1'b1;
      load(0, 16'h0003, 16'h0001);
      pwm_en <= 6'h01;
      repeat (20) @(posedge clk_sys);
      measure(0, 48, h, r);
      check("align highs", h, hexp[a]);
      check("align rises", r, rexp[a]);
    end
  endtask
  task automatic t_flags();
    int h, r, n;
    @(posedge clk_sys);
    int_en <= 12'h001;
    clk_en <= 1'b0;
    measure(0, 20, h, r);
    check("frozen rises", r, 0);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    check("match flags", flag_q[1:0], 2'h3);
    check("irq on", pwm_irq, 1'b1);
    // clear held high: only a match in the same cycle can show the flag
    @(posedge clk_sys);
    flag_clr <= 12'h001;
    repeat (2) @(posedge clk_sys);
    n = 0;
    repeat (8) begin
      @(negedge clk_sys);
      n += flag_q[0];
    end
    check("set beats clear", n, 2);
    @(posedge clk_sys);
    flag_clr <= 12'h000;
    @(posedge clk_sys);
    int_en <= 12'h000;
    pwm_en <= 6'h00;
    repeat (3) @(posedge clk_sys);
    #1;
    check("irq masked", pwm_irq, 1'b0);
    @(posedge clk_sys);
    flag_clr <= 12'hFFF;
    @(posedge clk_sys);
    flag_clr <= 12'h000;
    #1;
    check("flags cleared", flag_q, 12'h000);
  endtask
  task automatic t_oneshot();
    @(posedge clk_sys);
    one_shot <= 6'h02;
    load(1, 16'h0003, 16'h0001);
    pwm_en <= 6'h02;
    repeat (3) @(posedge clk_sys);
    #1;
    check("shot running", run_q[1], 1'b1);
    repeat (10) @(posedge clk_sys);
    #1;
    check("shot ended", {run_q[1], pins[1]}, 2'h0);
    @(posedge clk_sys);
    pwm_en <= 6'h00;
    align <= `SMP_ALIGN_CENTER;
    @(posedge clk_sys);
    pwm_en <= 6'h02;
    repeat (30) @(posedge clk_sys);
    #1;
    check("center reloads", run_q[1], 1'b1);
    @(posedge clk_sys);
    pwm_en <= 6'h00;
    one_shot <= 6'h00;
    align <= `SMP_ALIGN_EDGE;
  endtask
  task automatic t_presc();
    int h, r;
    presc_val <= 24'h000100;
    div_sel <= 18'h03040;
    load(2, 16'h0003, 16'h0001);
    load(4, 16'h0003, 16'h0001);
    pwm_en <= 6'h14;
    repeat (40) @(posedge clk_sys);
    measure(2, 64, h, r);
    check("prescaled rises", r, 4);
    measure(4, 64, h, r);
    check("divided rises", r, 2);
    @(posedge clk_sys);
    pwm_en <= 6'h00;
  endtask
  task automatic t_grp();
    int h, r;
    load(0, 16'h0003, 16'h0001);
    load(1, 16'h0007, 16'h0003);
    grp_en <= 1'b1;
    pwm_en <= 6'h03;
    repeat (20) @(posedge clk_sys);
    measure(5, 48, h, r);
    check("group odd", r, 6);
    @(posedge clk_sys);
    pair_mode <= `SMP_PAIR_SYNC;
    repeat (4) @(posedge clk_sys);
    measure(5, 48, h, r);
    check("sync pair", r, 12);
  endtask
  task automatic t_comp();
    int h, r;
    @(posedge clk_sys);
    grp_en <= 1'b0;
    pwm_en <= 6'h00;
    // enter complementary mode only once the sync pins have gone low
    load(0, 16'h0007, 16'h0003);
    pair_mode <= `SMP_PAIR_COMP;
    for (int d = 0; d <= 2; d += 2) begin
      @(posedge clk_sys);
      dead_time <= 24'(d);
      pwm_en <= 6'h01;
      repeat (20) @(posedge clk_sys);
      measure(0, 48, h, r);
      check("high side", h, 6 * (4 - d));
      measure(1, 48, h, r);
      check("low side", h, 6 * (4 - d));
    end
    check("overlap", shoot, 0);
  endtask
  task automatic t_buf();
    int h, r;
    @(posedge clk_sys);
    pair_mode <= `SMP_PAIR_INDEP;
    load(0, 16'h0003, 16'h0001);
    repeat (20) @(posedge clk_sys);
    measure(0, 48, h, r);
    check("short period", r, 12);
    load(0, 16'h0007, 16'h0003);
    repeat (20) @(posedge clk_sys);
    measure(0, 48, h, r);
    check("new period", r, 6);
  endtask
  initial begin
    {rst_n, grp_en, center_load, pwm_en, one_shot, buf_wr, pair_mode, align} = '0;
    {presc_val, dead_time, div_sel, buf_prd, buf_cdn, buf_cup, int_en, flag_clr} = '0;
    clk_en = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_align();
    t_flags();
    t_oneshot();
    t_presc();
    t_grp();
    t_comp();
    t_buf();
    results();
  end
endmodule
bind smp_pwm_unit smp_pwm_unit_asserts smp_pwm_unit_asserts_i (.clk_sys, .rst_n, .clk_en,
  .pwm_en, .pair_mode, .grp_en, .align, .one_shot, .int_en, .flag_clr, .pwm_out_0,
  .pwm_out_1, .pwm_out_2, .pwm_out_3, .pwm_out_4, .pwm_out_5, .flag_q, .pwm_irq, .run_q);
